// *** pkg/ipu_defines.svh ***
// register map, field positions, reset values and burst codes of the prefetch unit
`ifndef IPU_DEFINES_SVH
`define IPU_DEFINES_SVH
`define IPU_OFF_CTRL 8'h00
`define IPU_OFF_MODE 8'h04
`define IPU_OFF_CACHE 8'h08
`define IPU_OFF_IPTR 8'h0C
`define IPU_OFF_STAT 8'h10
`define IPU_CTRL_PF_EN 0
`define IPU_CTRL_FLUSH 5
`define IPU_MODE_BL_LO 0
`define IPU_MODE_BL_HI 1
`define IPU_MODE_OPC 2
`define IPU_CACHE_CLS_HI 7
`define IPU_CACHE_EN 8
`define IPU_BL_2 2'h0
`define IPU_BL_4 2'h1
`define IPU_BL_8 2'h2
`define IPU_BL_16 2'h3
`define IPU_DW_1 5'h01
`define IPU_DW_2 5'h02
`define IPU_DW_4 5'h04
`define IPU_DW_8 5'h08
`define IPU_DW_16 5'h10
`define IPU_DW_0 5'h00
`define IPU_FIFO_BYTES 8'h50
`define IPU_BUF_DEPTH 8
`define IPU_BUF_AW 3
`define IPU_RESP_OKAY 2'h0
`define IPU_RESP_SLVERR 2'h2
`define IPU_RST_WORD 32'h0000_0000
`endif

// *** pkg/ipu_pkg.sv ***
// types of the instruction prefetch unit
package ipu_pkg;
    typedef enum logic [2:0]
    {
        IPU_IDLE = 3'b001,
        IPU_REQ = 3'b010,
        IPU_DATA = 3'b100
    } ipu_state_t;
    typedef logic [4:0] ipu_dwords_t;
endpackage

// *** rtl/ipu_buffer.sv ***
// prefetch line store with registered read data
`timescale 1ns/1ps
`include "ipu_defines.svh"
module ipu_buffer
(
    input wire logic aclk,
    input wire logic wr_en,
    input wire logic [`IPU_BUF_AW-1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [`IPU_BUF_AW-1:0] rd_idx,
    output logic [31:0] rd_data
);
    logic [31:0] mem [0:`IPU_BUF_DEPTH-1];

    always_ff @(posedge aclk)
    begin
        if (wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// *** rtl/ipu_top.sv ***
// instruction prefetch unit with axi4-lite register slave
// Function
// - prefetch four or eight dwords while enabled
// - pick burst from burst length, cache line
// - disable itself if bursts below four dwords
// - memory move instruction flushes buffer
// - no-flush memory move keeps buffer intact
// - store flushes unless its no-flush option
// - any instruction pointer write flushes buffer
// - taken transfer control flushes, failed does not
// - flush bit five flushes, then self-clears
// - dma bursts 2,4,8,16 dwords, 80-byte fifo
// - opcode burst only while prefetching disabled
`timescale 1ns/1ps
`include "ipu_defines.svh"
module ipu_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic instr_req,
    input wire logic [31:0] instr_addr,
    output logic instr_valid,
    output logic [31:0] instr_data,
    input wire logic exec_memory_move_instr,
    input wire logic exec_noflush_memory_move_instr,
    input wire logic exec_store,
    input wire logic exec_store_noflush,
    input wire logic exec_xfer_taken,
    input wire logic exec_xfer_not_taken,
    input wire logic script_iptr_write,
    input wire logic [31:0] script_iptr_data,
    output logic [31:0] instr_ptr,
    output logic dma_req,
    output logic [31:0] dma_addr,
    output logic [4:0] dma_len,
    input wire logic dma_ack,
    input wire logic dma_rvalid,
    input wire logic [31:0] dma_rdata
);
    logic [31:0] dma_control_reg;
    logic [31:0] dma_mode_reg;
    logic [31:0] cache_config_reg;
    logic [31:0] instr_ptr_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic host_iptr_write;
    logic flush_now;
    logic [31:0] stat_word;
    logic [7:0] rd_sel;
    ipu_pkg::ipu_state_t state_reg;
    ipu_pkg::ipu_dwords_t mode_limit;
    ipu_pkg::ipu_dwords_t burst_limit;
    ipu_pkg::ipu_dwords_t pf_size;
    ipu_pkg::ipu_dwords_t fetch_len;
    logic pf_active;
    logic [31:0] base_reg;
    logic [3:0] valid_cnt_reg;
    logic [4:0] recv_cnt_reg;
    logic discard_reg;
    logic serve_reg;
    logic [29:0] word_off;
    logic hit;
    logic start_fetch;
    logic start_serve;
    logic [31:0] buf_rd_data;
    logic [4:0] cls_dw;

    // byte-lane merge of a write into an existing register value
    function automatic logic [31:0] ipu_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        ipu_merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign host_iptr_write = do_write & (aw_addr_reg == `IPU_OFF_IPTR);

    // axi write channels: address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPU_RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg <= `IPU_RST_WORD;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg <= s_axi_awaddr[7:0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    `IPU_OFF_CTRL, `IPU_OFF_MODE, `IPU_OFF_CACHE, `IPU_OFF_IPTR:
                        s_axi_bresp <= `IPU_RESP_OKAY;
                    default:
                        s_axi_bresp <= `IPU_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control register: the flush bit clears itself once acted on; a new set wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_control_reg <= `IPU_RST_WORD;
        end
        else if (do_write && aw_addr_reg == `IPU_OFF_CTRL)
        begin
            dma_control_reg <= ipu_merge(dma_control_reg, w_data_reg, w_strb_reg) &
                32'h0000_0021;
        end
        else if (dma_control_reg[`IPU_CTRL_FLUSH])
        begin
            dma_control_reg[`IPU_CTRL_FLUSH] <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_mode_reg <= `IPU_RST_WORD;
            cache_config_reg <= `IPU_RST_WORD;
        end
        else if (do_write)
        begin
            if (aw_addr_reg == `IPU_OFF_MODE)
            begin
                dma_mode_reg <= ipu_merge(dma_mode_reg, w_data_reg, w_strb_reg) &
                    32'h0000_0007;
            end
            if (aw_addr_reg == `IPU_OFF_CACHE)
            begin
                cache_config_reg <= ipu_merge(cache_config_reg, w_data_reg, w_strb_reg) &
                    32'h0000_01FF;
            end
        end
    end

    // instruction pointer; a script write in the same cycle as a host write wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_ptr_reg <= `IPU_RST_WORD;
        end
        else if (script_iptr_write)
        begin
            instr_ptr_reg <= script_iptr_data;
        end
        else if (host_iptr_write)
        begin
            instr_ptr_reg <= ipu_merge(instr_ptr_reg, w_data_reg, w_strb_reg);
        end
    end

    assign instr_ptr = instr_ptr_reg;

    // burst sizing: dma burst length, trimmed by cache line when cache mode is on
    always_comb
    begin
        case (dma_mode_reg[`IPU_MODE_BL_HI:`IPU_MODE_BL_LO])
            `IPU_BL_2: mode_limit = `IPU_DW_2;
            `IPU_BL_4: mode_limit = `IPU_DW_4;
            `IPU_BL_8: mode_limit = `IPU_DW_8;
            `IPU_BL_16: mode_limit = `IPU_DW_16;
            default: mode_limit = `IPU_DW_2;
        endcase
    end

    // line sizes above sixteen dwords cannot trim the burst, so saturate them
    assign cls_dw = (cache_config_reg[`IPU_CACHE_CLS_HI:0] > 8'h10) ? `IPU_DW_16 :
        cache_config_reg[4:0];
    assign burst_limit = (cache_config_reg[`IPU_CACHE_EN] && cls_dw < mode_limit) ?
        cls_dw : mode_limit;

    always_comb
    begin
        if (burst_limit >= `IPU_DW_8)
        begin
            pf_size = `IPU_DW_8;
        end
        else if (burst_limit >= `IPU_DW_4)
        begin
            pf_size = `IPU_DW_4;
        end
        else
        begin
            pf_size = `IPU_DW_0;
        end
    end

    assign pf_active = dma_control_reg[`IPU_CTRL_PF_EN] && (pf_size != `IPU_DW_0);
    // opcode burst of two dwords is honoured only without prefetching
    assign fetch_len = pf_active ? pf_size :
        (dma_mode_reg[`IPU_MODE_OPC] ? `IPU_DW_2 : `IPU_DW_1);

    // the no-flush move, no-flush store and failed transfer inputs never flush
    assign flush_now = exec_memory_move_instr
        | exec_store
        | script_iptr_write | host_iptr_write
        | exec_xfer_taken
        | dma_control_reg[`IPU_CTRL_FLUSH];

    assign word_off = instr_addr[31:2] - base_reg[31:2];
    assign hit = (word_off < {26'h0, valid_cnt_reg});
    assign start_serve = (state_reg == ipu_pkg::IPU_IDLE) && instr_req && hit &&
        !serve_reg && !instr_valid && !flush_now;
    assign start_fetch = (state_reg == ipu_pkg::IPU_IDLE) && instr_req && !hit &&
        !serve_reg && !instr_valid && !flush_now;

    // fetch sequencer toward the dma path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ipu_pkg::IPU_IDLE;
            dma_req <= 1'b0;
            dma_addr <= `IPU_RST_WORD;
            dma_len <= `IPU_DW_0;
            base_reg <= `IPU_RST_WORD;
            recv_cnt_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                ipu_pkg::IPU_IDLE:
                begin
                    if (start_fetch)
                    begin
                        // refetch begins at the address the core now asks for
                        dma_req <= 1'b1;
                        dma_addr <= {instr_addr[31:2], 2'b00};
                        dma_len <= fetch_len;
                        base_reg <= {instr_addr[31:2], 2'b00};
                        recv_cnt_reg <= 5'h00;
                        state_reg <= ipu_pkg::IPU_REQ;
                    end
                end
                ipu_pkg::IPU_REQ:
                begin
                    if (dma_ack)
                    begin
                        dma_req <= 1'b0;
                        state_reg <= ipu_pkg::IPU_DATA;
                    end
                end
                ipu_pkg::IPU_DATA:
                begin
                    if (dma_rvalid)
                    begin
                        recv_cnt_reg <= recv_cnt_reg + 5'h01;
                        if (recv_cnt_reg + 5'h01 == dma_len)
                        begin
                            state_reg <= ipu_pkg::IPU_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ipu_pkg::IPU_IDLE;
                    dma_req <= 1'b0;
                end
            endcase
        end
    end

    // a flush mid-burst lets the burst finish but keeps none of its dwords
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            discard_reg <= 1'b0;
        end
        else if (start_fetch)
        begin
            discard_reg <= 1'b0;
        end
        else if (flush_now && state_reg != ipu_pkg::IPU_IDLE)
        begin
            discard_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            valid_cnt_reg <= 4'h0;
        end
        else if (flush_now || start_fetch)
        begin
            valid_cnt_reg <= 4'h0;
        end
        else if (state_reg == ipu_pkg::IPU_DATA && dma_rvalid && !discard_reg)
        begin
            valid_cnt_reg <= valid_cnt_reg + 4'h1;
        end
    end

    ipu_buffer u_buffer
    (
        .aclk(aclk),
        .wr_en(state_reg == ipu_pkg::IPU_DATA && dma_rvalid),
        .wr_idx(recv_cnt_reg[`IPU_BUF_AW-1:0]),
        .wr_data(dma_rdata),
        .rd_en(start_serve),
        .rd_idx(word_off[`IPU_BUF_AW-1:0]),
        .rd_data(buf_rd_data)
    );

    // a flush during the read cancels the hand-off so the core never sees stale code
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serve_reg <= 1'b0;
            instr_valid <= 1'b0;
            instr_data <= `IPU_RST_WORD;
        end
        else
        begin
            serve_reg <= start_serve;
            instr_valid <= serve_reg && !flush_now;
            if (serve_reg)
            begin
                instr_data <= buf_rd_data;
            end
        end
    end

    assign stat_word = {8'h00, `IPU_FIFO_BYTES, 2'h0, (state_reg != ipu_pkg::IPU_IDLE),
        valid_cnt_reg, 3'h0, pf_size, pf_active};
    assign rd_sel = s_axi_araddr[7:0];

    // axi read channel, one read at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `IPU_RST_WORD;
            s_axi_rresp <= `IPU_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `IPU_RESP_OKAY;
                case (rd_sel)
                    `IPU_OFF_CTRL: s_axi_rdata <= dma_control_reg;
                    `IPU_OFF_MODE: s_axi_rdata <= dma_mode_reg;
                    `IPU_OFF_CACHE: s_axi_rdata <= cache_config_reg;
                    `IPU_OFF_IPTR: s_axi_rdata <= instr_ptr_reg;
                    `IPU_OFF_STAT: s_axi_rdata <= stat_word;
                    default:
                    begin
                        s_axi_rdata <= `IPU_RST_WORD;
                        s_axi_rresp <= `IPU_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// *** tb/ipu_checker.sv ***
// concurrent checks on the prefetch unit ports
`timescale 1ns/1ps
module ipu_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic script_iptr_write,
    input wire logic [31:0] script_iptr_data,
    input wire logic [31:0] instr_ptr,
    input wire logic instr_valid,
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic [31:0] dma_addr,
    input wire logic [4:0] dma_len
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_dma_wait;
        dma_req && !dma_ack;
    endsequence
    a_write_resp: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response not on time");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    a_dma_hold: assert property (s_dma_wait |=> dma_req && $stable(dma_addr) && $stable(dma_len))
        else $error("fetch request changed before accept");
    a_dma_len: assert property (dma_req |-> dma_len inside {5'h01, 5'h02, 5'h04, 5'h08})
        else $error("illegal fetch length");
    a_ack_drops: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("fetch request held after accept");
    a_ptr_write: assert property (script_iptr_write |=> instr_ptr == $past(script_iptr_data))
        else $error("pointer write not taken");
    a_valid_pulse: assert property (instr_valid |=> !instr_valid)
        else $error("instruction strobe held too long");
endmodule

// *** tb/ipu_dma_model.sv ***
// host memory behind the bus-master path, prompt or slow
`timescale 1ns/1ps
module ipu_dma_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic dma_req,
    input wire logic [31:0] dma_addr,
    input wire logic [4:0] dma_len,
    output logic dma_ack,
    output logic dma_rvalid,
    output logic [31:0] dma_rdata,
    output int n_fetch,
    output logic [4:0] last_len
);
    logic [31:0] a;
    int n;
    initial
    begin
        dma_ack = 1'b0;
        dma_rvalid = 1'b0;
        dma_rdata = 32'hFFFF_FFFF;
        n_fetch = 0;
        last_len = 5'h00;
        forever
        begin
            @(posedge aclk);
            if (aresetn && dma_req && !dma_ack)
            begin
                // slow answer makes the unit hold its request
                if (slow)
                    repeat (3) @(posedge aclk);
                a = dma_addr;
                n = dma_len;
                n_fetch++;
                last_len <= dma_len;
                dma_ack <= 1'b1;
                @(posedge aclk);
                dma_ack <= 1'b0;
                for (int i = 0; i < n; i++)
                begin
                    if (slow)
                    begin
                        dma_rvalid <= 1'b0;
                        dma_rdata <= ~dma_rdata;
                        @(posedge aclk);
                    end
                    dma_rvalid <= 1'b1;
                    dma_rdata <= (a + 32'(4 * i)) ^ 32'hC3C3_0000;
                    @(posedge aclk);
                end
                dma_rvalid <= 1'b0;
                // released data lines never show the last word
                dma_rdata <= ~dma_rdata;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the prefetch unit
`timescale 1ns/1ps
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, slow;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, instr_addr, instr_data;
    logic [31:0] script_iptr_data, instr_ptr, dma_addr, dma_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic instr_req, instr_valid, dma_req, dma_ack, dma_rvalid;
    logic [4:0] dma_len, last_len;
    logic [6:0] ev;
    int n_fetch, err_total, n_checks, cyc;
    wire exec_memory_move_instr = ev[0];
    wire exec_noflush_memory_move_instr = ev[1];
    wire exec_store = ev[2];
    wire exec_store_noflush = ev[3];
    wire exec_xfer_taken = ev[4];
    wire exec_xfer_not_taken = ev[5];
    wire script_iptr_write = ev[6];
    ipu_top u_ipu_top (.*);
    ipu_dma_model u_ipu_dma_model (.*);
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        s_axi_awaddr <= {24'h000000, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= {24'h000000, a};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic fetch(input logic [31:0] a);
        instr_addr <= a;
        instr_req <= 1'b1;
        do @(posedge aclk); while (instr_valid !== 1'b1);
        instr_req <= 1'b0;
        chk("instr_data", a ^ 32'hC3C3_0000, instr_data);
        @(posedge aclk);
    endtask
    task automatic t_regs();
        rd(8'h00);
        chk("ctrl", 32'h0000_0000, d);
        rd(8'h10);
        chk("fifo", 32'h0000_0050, {24'h0, d[23:16]});
        rd(8'h20);
        chk("rresp", 32'h2, {30'h0, r});
        wr(8'h10, 32'hFFFF_FFFF);
        chk("bresp", 32'h2, {30'h0, r});
        $display("t_regs done");
    endtask
    task automatic t_burst();
        logic [31:0] cv[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h104, 32'h102};
        logic [4:0] sz[6] = '{5'h00, 5'h04, 5'h08, 5'h08, 5'h04, 5'h00};
        wr(8'h00, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h08, cv[i]);
            wr(8'h04, (i < 4) ? 32'(i) : 32'h3);
            rd(8'h10);
            chk("size", {27'h0, sz[i]}, {27'h0, d[5:1]});
            chk("active", {31'h0, sz[i] != 5'h00}, {31'h0, d[0]});
        end
        wr(8'h08, 32'h0);
        $display("t_burst done");
    endtask
    task automatic t_flush();
        int n0;
        logic [8:0] fl = 9'b1_1101_0101;
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        wr(8'h0C, 32'h104);
        fetch(32'h104);
        chk("len", 32'h8, {27'h0, last_len});
        n0 = n_fetch;
        fetch(32'h11C);
        chk("hit", 32'h0, 32'(n_fetch - n0));
        for (int k = 0; k < 9; k++)
        begin
            slow <= k[0];
            if (k < 7)
            begin
                ev <= 7'(1 << k);
                @(posedge aclk);
                ev <= 7'h00;
            end
            else if (k == 7)
                wr(8'h0C, 32'h104);
            else
                wr(8'h00, 32'h21);
            repeat (3) @(posedge aclk);
            n0 = n_fetch;
            fetch(32'h104);
            chk("refetch", {31'h0, fl[k]}, 32'(n_fetch - n0));
        end
        chk("iptr", 32'h104, instr_ptr);
        rd(8'h00);
        chk("flush bit", 32'h1, d);
        $display("t_flush done");
    endtask
    task automatic t_opcode();
        logic [31:0] mv[3] = '{32'h4, 32'h0, 32'h6};
        logic [4:0] ln[3] = '{5'h02, 5'h01, 5'h08};
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h00, (i == 2) ? 32'h1 : 32'h0);
            wr(8'h04, mv[i]);
            fetch(32'h200 + 32'(i * 256));
            chk("len", {27'h0, ln[i]}, {27'h0, last_len});
        end
        $display("t_opcode done");
    endtask
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, instr_addr} = 128'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hF;
        script_iptr_data = 32'h104;
        instr_req = 1'b0;
        slow = 1'b0;
        ev = 7'h00;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_burst();
        t_flush();
        t_opcode();
        report_and_stop();
    end
endmodule
bind ipu_top ipu_checker u_ipu_checker (.*);
